// ---- hdl/dmacc_defs.svh ----
/*
 dma channel control constants: register indices, field positions, reset values and codes.
 assumes an APB slave with a 12-bit byte address, each register one aligned word.
*/
`ifndef DMACC_DEFS_SVH
`define DMACC_DEFS_SVH

// printed offsets are register indices; byte address is four times the low ten bits of the index
`define DMACC_IDX_SRC_LO   32'h50003500
`define DMACC_IDX_SRC_HI   32'h50003502
`define DMACC_IDX_DST_LO   32'h50003504
`define DMACC_IDX_DST_HI   32'h50003506
`define DMACC_IDX_IRQ_CNT  32'h50003508
`define DMACC_IDX_LENGTH   32'h5000350a
`define DMACC_IDX_CONTROL  32'h5000350c
`define DMACC_IDX_ITEM     32'h5000350e
`define DMACC_BYTE_ADDR(i) 12'(((i) & 32'h000003ff) << 2)

`define DMACC_RST16        16'h0000
`define DMACC_RST32        32'h00000000
`define DMACC_CTL_MASK     16'h1fff
`define DMACC_CTL_ON       0
`define DMACC_CTL_BW_LO    1
`define DMACC_CTL_BW_HI    2
`define DMACC_CTL_IRQ_EN   3
`define DMACC_CTL_TRIG     4
`define DMACC_CTL_DST_INC  5
`define DMACC_CTL_SRC_INC  6
`define DMACC_CTL_CIRC     7
`define DMACC_CTL_PRIO_LO  8
`define DMACC_CTL_PRIO_HI  10
`define DMACC_CTL_IDLE     11
`define DMACC_CTL_FILL     12

`define DMACC_BW_BYTE      2'h0
`define DMACC_BW_HALF      2'h1
`define DMACC_BW_WORD      2'h2
`define DMACC_SHIFT_BYTE   2'h0
`define DMACC_SHIFT_HALF   2'h1
`define DMACC_SHIFT_WORD   2'h2

`define DMACC_NUM_CHAN     8
`define DMACC_PEERS        7
`define DMACC_CHAN_ID      3'h0
`define DMACC_NO_CHAN      3'h7
`define DMACC_ITEM_STEP    16'h0001

`endif

// ---- hdl/dmacc_pkg.sv ----
/*
 types for the dma channel control block: fsm states, bus command and response, apb request.
 assumes the constants header is included by the design file.
*/
package dmacc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_GAP   = 4'h8
    } dmacc_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dmacc_bus_cmd_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } dmacc_bus_rsp_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dmacc_apb_req_t;

endpackage

// ---- hdl/dmacc_top.sv ----
/*
 one dma channel: apb register file, item sequencer and the bus arbiter over eight channels.
 assumes the system bus answers each command with a one-cycle ack, and that peer channels
 present their request and priority fields synchronous to REF_CLK.
*/
`timescale 1ns/100ps
`include "dmacc_defs.svh"

module dmacc_top
    import dmacc_pkg::*;
(
    // clock and reset
    input  wire logic                           REF_CLK,
    input  wire logic                           NRST,
    // apb slave
    input  wire dmacc_apb_req_t                 APB_REQ,
    output logic [31:0]                         PRDATA,
    output logic                                PREADY,
    output logic                                PSLVERR,
    // system bus master
    output dmacc_bus_cmd_t                      BUS_CMD,
    input  wire dmacc_bus_rsp_t                 BUS_RSP,
    output logic                                BUS_LOCK,
    // peripheral request and arbitration
    input  wire logic                           PERIPH_REQ,
    input  wire logic [`DMACC_PEERS-1:0]        PEER_REQ,
    input  wire logic [3*`DMACC_PEERS-1:0]      PEER_PRIO,
    output logic [`DMACC_NUM_CHAN-1:0]          GRANT,
    // status
    output logic                                IRQ_PULSE,
    output logic                                CHAN_CLK_EN
);

    logic [15:0]    src_lo_reg;
    logic [15:0]    src_hi_reg;
    logic [15:0]    dst_lo_reg;
    logic [15:0]    dst_hi_reg;
    logic [15:0]    irq_count_match_reg;
    logic [15:0]    transfer_length_reg;
    logic [15:0]    channel_control_reg;
    logic [15:0]    channel_control_next;
    logic [15:0]    item_index_reg;
    logic [15:0]    item_index_next;
    logic [31:0]    data_reg;
    logic [31:0]    prdata_reg;
    logic           ack_reg;
    logic           err_reg;
    logic           irq_reg;
    dmacc_state_t   state_reg;
    dmacc_state_t   state_next;
    dmacc_bus_cmd_t cmd_reg;
    dmacc_bus_cmd_t cmd_next;

    // control fields
    wire       on_bit    = channel_control_reg[`DMACC_CTL_ON];
    wire [1:0] bw_field  = channel_control_reg[`DMACC_CTL_BW_HI:`DMACC_CTL_BW_LO];
    wire       irq_en    = channel_control_reg[`DMACC_CTL_IRQ_EN];
    wire       trig_mode = channel_control_reg[`DMACC_CTL_TRIG];
    wire       dst_inc   = channel_control_reg[`DMACC_CTL_DST_INC];
    wire       src_inc   = channel_control_reg[`DMACC_CTL_SRC_INC];
    wire       circ_bit  = channel_control_reg[`DMACC_CTL_CIRC];
    wire [2:0] prio_fld  = channel_control_reg[`DMACC_CTL_PRIO_HI:`DMACC_CTL_PRIO_LO];
    wire       idle_bit  = channel_control_reg[`DMACC_CTL_IDLE];
    wire       fill_bit  = channel_control_reg[`DMACC_CTL_FILL];

    // apb decode; one wait state so read data leaves a flip-flop
    wire        apb_acc  = APB_REQ.psel & APB_REQ.penable;
    wire        apb_done = apb_acc & ack_reg;
    wire [11:0] pa       = APB_REQ.paddr;
    wire        hit_slo  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_SRC_LO);
    wire        hit_shi  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_SRC_HI);
    wire        hit_dlo  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_DST_LO);
    wire        hit_dhi  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_DST_HI);
    wire        hit_cnt  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_IRQ_CNT);
    wire        hit_len  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_LENGTH);
    wire        hit_ctl  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_CONTROL);
    wire        hit_idx  = pa == `DMACC_BYTE_ADDR(`DMACC_IDX_ITEM);
    wire        hit_any  = hit_slo | hit_shi | hit_dlo | hit_dhi | hit_cnt | hit_len
                           | hit_ctl | hit_idx;
    // index is read-only: a write to it is answered with an error
    wire        bad_acc  = !hit_any | (hit_idx & APB_REQ.pwrite);
    wire        wr_en    = apb_done & APB_REQ.pwrite & !bad_acc;
    wire        wr_ctl   = wr_en & hit_ctl;
    wire [15:0] wdata16  = APB_REQ.pwdata[15:0];

    wire [15:0] rd_mux = hit_slo ? src_lo_reg :
                         hit_shi ? src_hi_reg :
                         hit_dlo ? dst_lo_reg :
                         hit_dhi ? dst_hi_reg :
                         hit_cnt ? irq_count_match_reg :
                         hit_len ? transfer_length_reg :
                         hit_ctl ? channel_control_reg :
                         hit_idx ? item_index_reg : `DMACC_RST16;

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            ack_reg    <= 1'b0;
            err_reg    <= 1'b0;
            prdata_reg <= `DMACC_RST32;
        end else begin
            ack_reg    <= apb_acc & !ack_reg;
            err_reg    <= apb_acc & !ack_reg & bad_acc;
            prdata_reg <= (apb_acc & !ack_reg & !APB_REQ.pwrite) ? {16'h0000, rd_mux}
                                                                 : `DMACC_RST32;
        end
    end

    assign PRDATA  = prdata_reg;
    assign PREADY  = ack_reg;
    assign PSLVERR = err_reg;

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            src_lo_reg          <= `DMACC_RST16;
            src_hi_reg          <= `DMACC_RST16;
            dst_lo_reg          <= `DMACC_RST16;
            dst_hi_reg          <= `DMACC_RST16;
            irq_count_match_reg <= `DMACC_RST16;
            transfer_length_reg <= `DMACC_RST16;
        end else if (wr_en) begin
            if (hit_slo) src_lo_reg <= wdata16;
            if (hit_shi) src_hi_reg <= wdata16;
            if (hit_dlo) dst_lo_reg <= wdata16;
            if (hit_dhi) dst_hi_reg <= wdata16;
            if (hit_cnt) irq_count_match_reg <= wdata16;
            if (hit_len) transfer_length_reg <= wdata16;
        end
    end

    // item sequencing
    wire        busy      = (state_reg == ST_READ) | (state_reg == ST_WRITE);
    wire        bus_ack   = BUS_RSP.ack & busy;
    wire        store_ack = bus_ack & (state_reg == ST_WRITE);
    wire        last_item = item_index_reg == transfer_length_reg;
    wire        restart   = circ_bit & trig_mode;
    wire        trig_ok   = !trig_mode | PERIPH_REQ;
    // a request trigger paces each item itself, so idle insertion has no meaning there
    wire        blocking  = fill_bit | (!trig_mode & !idle_bit);
    wire        insert_gap = !trig_mode & idle_bit & !fill_bit;
    wire        chan_req  = on_bit & (busy | trig_ok);
    wire        hold_self = busy;
    wire        irq_hit   = store_ack & irq_en & (irq_count_match_reg == item_index_reg);
    wire [1:0]  shift     = (bw_field == `DMACC_BW_HALF) ? `DMACC_SHIFT_HALF :
                            (bw_field == `DMACC_BW_WORD) ? `DMACC_SHIFT_WORD :
                            `DMACC_SHIFT_BYTE;
    logic       grant_self;

    function automatic logic [31:0] item_addr(input logic [31:0] start, input logic inc,
                                              input logic [15:0] idx, input logic [1:0] sh);
        logic [31:0] off;
        off = {16'h0000, idx} << sh;
        item_addr = inc ? start + off : start;
    endfunction

    always_comb begin
        state_next      = state_reg;
        item_index_next = item_index_reg;
        case (state_reg)
            ST_IDLE: begin
                if (on_bit & trig_ok & grant_self)
                    state_next = (fill_bit & (item_index_reg != `DMACC_RST16)) ? ST_WRITE
                                                                             : ST_READ;
            end
            ST_READ: begin
                if (bus_ack)
                    state_next = ST_WRITE;
            end
            ST_WRITE: begin
                if (store_ack) begin
                    if (last_item) begin
                        item_index_next = `DMACC_RST16;
                        state_next      = ST_IDLE;
                    end else begin
                        item_index_next = item_index_reg + `DMACC_ITEM_STEP;
                        state_next      = fill_bit    ? ST_WRITE :
                                          blocking    ? ST_READ  :
                                          insert_gap  ? ST_GAP   : ST_IDLE;
                    end
                end
            end
            ST_GAP: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
        // a switched-off channel abandons its item and forgets its position
        if (!on_bit) begin
            state_next      = ST_IDLE;
            item_index_next = `DMACC_RST16;
        end
    end

    // software writing the on bit wins over the automatic clear in the same cycle
    always_comb begin
        channel_control_next = channel_control_reg;
        if (store_ack & last_item & !restart)
            channel_control_next[`DMACC_CTL_ON] = 1'b0;
        if (wr_ctl)
            channel_control_next = wdata16 & `DMACC_CTL_MASK;
    end

    always_comb begin
        cmd_next       = '0;
        cmd_next.size  = bw_field;
        cmd_next.wdata = data_reg;
        if (state_next == ST_READ) begin
            cmd_next.valid = 1'b1;
            cmd_next.addr  = item_addr({src_hi_reg, src_lo_reg}, src_inc, item_index_next, shift);
        end else if (state_next == ST_WRITE) begin
            cmd_next.valid = 1'b1;
            cmd_next.write = 1'b1;
            cmd_next.addr  = item_addr({dst_hi_reg, dst_lo_reg}, dst_inc, item_index_next, shift);
            if (bus_ack & (state_reg == ST_READ))
                cmd_next.wdata = BUS_RSP.rdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            state_reg           <= ST_IDLE;
            item_index_reg      <= `DMACC_RST16;
            channel_control_reg <= `DMACC_RST16;
            data_reg            <= `DMACC_RST32;
            cmd_reg             <= '0;
            irq_reg             <= 1'b0;
        end else begin
            state_reg           <= state_next;
            item_index_reg      <= item_index_next;
            channel_control_reg <= channel_control_next;
            cmd_reg             <= cmd_next;
            irq_reg             <= irq_hit;
            if (bus_ack & (state_reg == ST_READ))
                data_reg <= BUS_RSP.rdata;
        end
    end

    assign BUS_CMD     = cmd_reg;
    assign IRQ_PULSE   = irq_reg;
    assign CHAN_CLK_EN = on_bit;
    assign BUS_LOCK    = on_bit & busy & blocking;

    // arbiter: scan from the top channel down; >= lets a lower number take a tie
    wire [`DMACC_NUM_CHAN-1:0]   all_req  = {PEER_REQ, chan_req & (state_reg == ST_IDLE)};
    wire [3*`DMACC_NUM_CHAN-1:0] all_prio = {PEER_PRIO, prio_fld};
    logic [`DMACC_NUM_CHAN:0]    win_valid;
    logic [2:0]                  win_prio [0:`DMACC_NUM_CHAN];
    logic [2:0]                  win_id   [0:`DMACC_NUM_CHAN];
    assign win_valid[`DMACC_NUM_CHAN] = 1'b0;
    assign win_prio[`DMACC_NUM_CHAN]  = 3'h0;
    assign win_id[`DMACC_NUM_CHAN]    = `DMACC_NO_CHAN;

    genvar gi;
    generate
        for (gi = 0; gi < `DMACC_NUM_CHAN; gi = gi + 1) begin : g_arb
            wire [2:0] p    = all_prio[3*gi +: 3];
            wire       take = all_req[gi] & (!win_valid[gi+1] | (p >= win_prio[gi+1]));
            assign win_valid[gi] = take | win_valid[gi+1];
            assign win_prio[gi]  = take ? p : win_prio[gi+1];
            assign win_id[gi]    = take ? 3'(gi) : win_id[gi+1];
            assign GRANT[gi]     = hold_self ? (3'(gi) == `DMACC_CHAN_ID)
                                             : (win_valid[0] & (win_id[0] == 3'(gi)));
        end
    endgenerate

    assign grant_self = GRANT[`DMACC_CHAN_ID];

    // checks
    logic peer_higher;
    always_comb begin
        peer_higher = 1'b0;
        for (int k = 0; k < `DMACC_PEERS; k++)
            if (PEER_REQ[k] & (PEER_PRIO[3*k +: 3] > prio_fld))
                peer_higher = 1'b1;
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence s_mid_store;
        store_ack & !last_item & on_bit & !wr_ctl;
    endsequence
    sequence s_gap_then_idle;
        (state_reg == ST_GAP) ##1 (state_reg == ST_IDLE);
    endsequence

    property p_irq_match;
        irq_hit |=> IRQ_PULSE;
    endproperty
    a_irq_match: assert property (p_irq_match) else $error("count match gave no pulse");

    property p_irq_gate;
        IRQ_PULSE |-> $past(irq_en) && $past(store_ack)
                      && $past(irq_count_match_reg) == $past(item_index_reg);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("pulse without enabled match");

    property p_len_end;
        (store_ack & last_item & on_bit) |=> item_index_reg == `DMACC_RST16;
    endproperty
    a_len_end: assert property (p_len_end) else $error("index not cleared at end");

    property p_fill_once;
        (state_reg == ST_READ) & fill_bit |-> item_index_reg == `DMACC_RST16;
    endproperty
    a_fill_once: assert property (p_fill_once) else $error("fill reread the source");

    property p_fill_hold;
        busy & fill_bit |-> GRANT == `DMACC_NUM_CHAN'(1) << `DMACC_CHAN_ID && BUS_LOCK;
    endproperty
    a_fill_hold: assert property (p_fill_hold) else $error("fill lost the bus");

    property p_block_b2b;
        s_mid_store ##0 (blocking & !fill_bit) |=> (state_reg == ST_READ) && BUS_LOCK;
    endproperty
    a_block_b2b: assert property (p_block_b2b) else $error("blocking copy not back to back");

    property p_idle_gap;
        s_mid_store ##0 insert_gap |=> s_gap_then_idle;
    endproperty
    a_idle_gap: assert property (p_idle_gap) else $error("no wait cycle after store");

    property p_trig_paced;
        s_mid_store ##0 (trig_mode & !fill_bit) |=> state_reg == ST_IDLE && !BUS_LOCK;
    endproperty
    a_trig_paced: assert property (p_trig_paced) else $error("trigger mode used idle bit");

    property p_prio;
        !hold_self & peer_higher |-> !GRANT[`DMACC_CHAN_ID];
    endproperty
    a_prio: assert property (p_prio) else $error("lower priority granted");

    property p_tie;
        !hold_self & chan_req & (state_reg == ST_IDLE) & !peer_higher |-> GRANT[`DMACC_CHAN_ID];
    endproperty
    a_tie: assert property (p_tie) else $error("tie not given to lowest channel");

    property p_stop;
        store_ack & last_item & !restart & !wr_ctl |=> !on_bit ##1 state_reg == ST_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("channel did not stop");

    property p_circ;
        store_ack & last_item & restart & !wr_ctl |=> on_bit && item_index_reg == `DMACC_RST16;
    endproperty
    a_circ: assert property (p_circ) else $error("circular restart failed");

    property p_src_fixed;
        BUS_CMD.valid & !BUS_CMD.write & !src_inc & !$past(wr_en)
            |-> BUS_CMD.addr == {src_hi_reg, src_lo_reg};
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("fixed source moved");

    // a held command was formed from the index it now shows, so the index register applies
    property p_src_step;
        BUS_CMD.valid & !BUS_CMD.write & src_inc & !$past(wr_en)
            |-> BUS_CMD.addr == {src_hi_reg, src_lo_reg} + ({16'h0000, item_index_reg} << shift);
    endproperty
    a_src_step: assert property (p_src_step) else $error("source step wrong");

    property p_dst_step;
        BUS_CMD.valid & BUS_CMD.write & dst_inc & !$past(wr_en)
            |-> BUS_CMD.addr == {dst_hi_reg, dst_lo_reg} + ({16'h0000, item_index_reg} << shift);
    endproperty
    a_dst_step: assert property (p_dst_step) else $error("destination step wrong");

    property p_wait_req;
        (state_reg == ST_IDLE) & trig_mode & !PERIPH_REQ |=> state_reg == ST_IDLE;
    endproperty
    a_wait_req: assert property (p_wait_req) else $error("moved without request");

    property p_off_idle;
        !on_bit |=> !BUS_CMD.valid && !IRQ_PULSE;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("off channel active");

endmodule // dmacc_top

// ---- tb/dmacc_mem_model.sv ----
/*
 system bus memory model: acks each command after a chosen wait, returns an address pattern.
 assumes one command at a time, held by the master until the ack edge.
*/
`timescale 1ns/100ps

module dmacc_mem_model
    import dmacc_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           nrst,
    input  wire dmacc_bus_cmd_t cmd,
    input  wire logic [3:0]     slow,
    output dmacc_bus_rsp_t      rsp,
    output logic [15:0]         rd_cnt,
    output logic [15:0]         wr_cnt,
    output logic [31:0]         last_waddr,
    output logic [31:0]         last_wdata
);
    logic [3:0] cnt;
    // rdata toggles outside ack so a stale sample never matches
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rsp <= '0;
            cnt <= 4'h0;
            rd_cnt <= 16'h0;
            wr_cnt <= 16'h0;
        end else if (cmd.valid && !rsp.ack && cnt >= slow) begin
            rsp.ack <= 1'b1;
            rsp.rdata <= {cmd.addr[15:0], ~cmd.addr[15:0]};
            cnt <= 4'h0;
            rd_cnt <= rd_cnt + {15'h0, !cmd.write};
            wr_cnt <= wr_cnt + {15'h0, cmd.write};
            if (cmd.write) begin
                last_waddr <= cmd.addr;
                last_wdata <= cmd.wdata;
            end
        end else begin
            rsp.ack <= 1'b0;
            rsp.rdata <= ~rsp.rdata;
            cnt <= cmd.valid ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule // dmacc_mem_model

// ---- tb/tb_top.sv ----
/*
 self-checking bench for the dma channel control block.
 assumes the memory model above; the watchdog ends any wait that hangs.
*/
`timescale 1ns/100ps
`include "dmacc_defs.svh"

module tb_top
    import dmacc_pkg::*;
;
    logic                         ref_clk = 1'b0;
    logic                         nrst = 1'b0;
    logic                         preq = 1'b0;
    dmacc_apb_req_t               apb = '0;
    dmacc_bus_cmd_t               cmd;
    dmacc_bus_rsp_t               rsp;
    logic [`DMACC_PEERS-1:0]      peer = '0;
    logic [3*`DMACC_PEERS-1:0]    prio = '0;
    logic [31:0]                  prdata, waddr, wdata, rv;
    logic [7:0]                   grant;
    logic [3:0]                   slow = 4'h0;
    logic [15:0]                  rds, wrs, r0, w0;
    logic                         pready, perr, lock, irq, clk_en, err;
    int                           fail_count = 0, checked = 0, irqs = 0, gaps, locks, g0;

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) irqs += (irq === 1'b1);

    dmacc_top dmacc_top_i (.REF_CLK(ref_clk), .NRST(nrst), .APB_REQ(apb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(perr), .BUS_CMD(cmd), .BUS_RSP(rsp), .BUS_LOCK(lock),
        .PERIPH_REQ(preq), .PEER_REQ(peer), .PEER_PRIO(prio), .GRANT(grant),
        .IRQ_PULSE(irq), .CHAN_CLK_EN(clk_en));
    dmacc_mem_model dmacc_mem_model_i (.clk(ref_clk), .nrst(nrst), .cmd(cmd), .slow(slow),
        .rsp(rsp), .rd_cnt(rds), .wr_cnt(wrs), .last_waddr(waddr), .last_wdata(wdata));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (fail_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d);
        apb <= '{1'b1, 1'b0, wr, a, {16'h0, d}};
        @(posedge ref_clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        err = perr;
        apb <= '0;
        // one idle edge so a following call never reassigns apb in the same step
        @(posedge ref_clk);
    endtask

    task automatic wait_off(input logic fire);
        gaps = 0;
        locks = 0;
        r0 = rds;
        w0 = wrs;
        @(posedge ref_clk);
        while (clk_en === 1'b1) begin
            @(posedge ref_clk);
            gaps += (cmd.valid !== 1'b1);
            locks += (lock === 1'b1);
            if (fire && cmd.valid === 1'b1) peer <= 7'h40;
        end
    endtask

    task automatic t_regs();
        xfer(1'b0, 12'h420, 16'h0); check("irq_count_match", rv, 32'h0);
        xfer(1'b0, 12'h428, 16'h0); check("transfer_length", rv, 32'h0);
        xfer(1'b0, 12'h438, 16'h0); check("item_index", rv, 32'h0);
        xfer(1'b1, 12'h438, 16'h5); check("index write err", err, 1'b1);
        xfer(1'b0, 12'h0fc, 16'h0); check("unmapped err", err, 1'b1);
        xfer(1'b1, 12'h430, 16'hfffe);
        xfer(1'b0, 12'h430, 16'h0); check("channel_control", rv, 32'h1ffe);
        check("gated", clk_en, 1'b0);
        xfer(1'b1, 12'h430, 16'h0);
    endtask

    task automatic t_copy(input logic [15:0] ctl, input logic [31:0] wa, input logic [15:0] wd);
        int i0;
        i0 = irqs;
        xfer(1'b1, 12'h430, ctl);
        wait_off(1'b0);
        check("reads", rds - r0, 3);
        check("writes", wrs - w0, 3);
        check("last dst", waddr, wa);
        check("last data", wdata[15:0], wd);
        check("irqs", irqs - i0, {31'h0, ctl[3]});
        xfer(1'b0, 12'h430, 16'h0); check("on cleared", rv, {16'h0, ctl & 16'hfffe});
        xfer(1'b0, 12'h438, 16'h0); check("index end", rv, 32'h0);
    endtask

    initial begin
        #100000;
        fail_count++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        xfer(1'b1, 12'h400, 16'h1000);
        xfer(1'b1, 12'h408, 16'h2000);
        xfer(1'b1, 12'h410, 16'h3000);
        xfer(1'b1, 12'h418, 16'h2000);
        xfer(1'b1, 12'h420, 16'h1);
        xfer(1'b1, 12'h428, 16'h2);
        t_copy(16'h006d, 32'h20003008, 16'heff7);
        check("lock", locks > 0, 1'b1);
        g0 = gaps;
        t_copy(16'h0803, 32'h20003000, 16'hefff);
        check("idle gaps", gaps >= g0 + 4, 1'b1);
        check("idle no lock", locks, 0);
        // fill keeps destination increment on and triggering off
        xfer(1'b1, 12'h428, 16'h3);
        slow <= 4'h2;
        prio <= 21'h1c0000;
        xfer(1'b1, 12'h430, 16'h1025);
        wait_off(1'b1);
        check("fill reads", rds - r0, 1);
        check("fill writes", wrs - w0, 4);
        check("fill dst", waddr, 32'h2000300c);
        check("fill data", wdata, 32'h1000efff);
        slow <= 4'h0;
        prio <= 21'h000000;
        peer <= 7'h06;
        @(posedge ref_clk);
        @(posedge ref_clk); check("tie peers", grant, 8'h04);
        prio <= 21'h000140;
        @(posedge ref_clk);
        @(posedge ref_clk); check("high peer", grant, 8'h08);
        peer <= 7'h01;
        prio <= 21'h000005;
        xfer(1'b1, 12'h428, 16'h0);
        xfer(1'b1, 12'h430, 16'h0305);
        r0 = rds;
        repeat (10) @(posedge ref_clk);
        check("denied", grant, 8'h02);
        check("no read", rds - r0, 0);
        prio <= 21'h000003;
        wait_off(1'b0);
        check("tie wins", rds - r0 + 16'h1, 2);
        peer <= '0;
        xfer(1'b1, 12'h428, 16'h1);
        xfer(1'b1, 12'h430, 16'h08f5);
        r0 = rds;
        w0 = wrs;
        repeat (20) @(posedge ref_clk);
        check("no trigger", rds - r0, 0);
        preq <= 1'b1;
        repeat (80) @(posedge ref_clk);
        check("circ writes", wrs - w0 >= 4, 1'b1);
        check("circ on", clk_en, 1'b1);
        preq <= 1'b0;
        xfer(1'b1, 12'h430, 16'h0);
        @(posedge ref_clk);
        check("off", clk_en, 1'b0);
        test_done();
    end
endmodule // tb_top
